// [hdl/fac_ctrl.sv]
module fac_ctrl
   import fac_pkg::*;
   (input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_rd,
    output logic [7:0]      sfr_rdata_q,
    output logic            core_stall_q,
    output logic            irq_defer_q);

   typedef enum logic [1:0] {S_IDLE, S_RUN, S_EPW} fac_state_t;

   fac_flash_if #(.AW(FAC_ADDR_W)) fl ();

   fac_flash_array #(.AW(FAC_ADDR_W), .PAGE_W(FAC_PAGE_W)) u_array (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .fl       (fl.array));

   fac_state_t              state_q;
   fac_state_t              state_d;
   logic [7:0]              cmd_q;
   logic [7:0]              key_q;
   logic [7:0]              pkey_q;
   logic [7:0]              data_q;
   logic [7:0]              wpl_q;
   logic [7:0]              wpm_q;
   logic [7:0]              rp_q;
   logic [7:0]              adl_q;
   logic [7:0]              adh_q;
   logic [31:0]             wp_act_q;
   logic [7:0]              rp_act_q;
   logic [7:0]              stored_key_q;
   logic                    start_q;
   fac_op_t                 op_q;
   fac_op_t                 op_d;
   logic [FAC_ADDR_W-1:0]   faddr_q;
   logic [FAC_ADDR_W-1:0]   faddr_d;
   logic [7:0]              fwdata_q;
   logic [7:0]              fwdata_d;
   logic                    go;
   logic                    cmd_wr;
   logic                    key_ok;
   logic                    launch;
   logic                    apply_masks;
   logic                    prot_allowed;
   logic                    fin;
   logic [FAC_ADDR_W-1:0]   addr14;
   logic [4:0]              page;

   assign fl.start  = start_q;
   assign fl.op     = op_q;
   assign fl.addr   = faddr_q;
   assign fl.wdata  = fwdata_q;

   assign addr14       = {adh_q[5:0], adl_q};
   assign page         = addr14[FAC_ADDR_W-1:FAC_PAGE_W];
   assign cmd_wr       = sfr_wr && sfr_addr == FAC_ADR_CMD && state_q == S_IDLE;
   assign key_ok       = key_q == FAC_UNLOCK_VALUE;
   assign prot_allowed = stored_key_q == FAC_ERASED || pkey_q == stored_key_q;
   assign launch       = cmd_wr && key_ok && go;
   assign apply_masks  = cmd_wr && key_ok && sfr_wdata == FAC_CMD_PROT && prot_allowed;
   assign fin          = state_q == S_RUN && fl.done;

   // Command decode
   always_comb begin
      go       = 1'b0;
      op_d     = FAC_OP_PROG;
      faddr_d  = addr14;
      fwdata_d = data_q;
      unique case (sfr_wdata)
         FAC_CMD_WRITE: go = wp_act_q[page];
         FAC_CMD_EPAGE: begin
            go   = wp_act_q[page];
            op_d = FAC_OP_EPAGE;
         end
         FAC_CMD_EALL: begin
            go   = &wp_act_q;
            op_d = FAC_OP_EALL;
         end
         FAC_CMD_READ: begin
            go   = rp_act_q[page[4:2]];
            op_d = FAC_OP_READ;
         end
         FAC_CMD_EPW: begin
            go   = wp_act_q[page];
            op_d = FAC_OP_EPAGE;
         end
         FAC_CMD_PROT: begin
            go       = stored_key_q == FAC_ERASED;
            faddr_d  = FAC_PKEY_LOC;
            fwdata_d = pkey_q;
         end
         default: go = 1'b0;
      endcase
   end

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         S_IDLE: if (launch) state_d = (sfr_wdata == FAC_CMD_EPW) ? S_EPW : S_RUN;
         S_EPW:  if (fl.done) state_d = S_RUN;
         S_RUN:  if (fl.done) state_d = S_IDLE;
      endcase
   end

   // Sequencer and array request
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q  <= S_IDLE;
         start_q  <= 1'b0;
         op_q     <= FAC_OP_PROG;
         faddr_q  <= '0;
         fwdata_q <= 8'h00;
      end else begin
         state_q <= state_d;
         start_q <= 1'b0;
         if (launch) begin
            start_q  <= 1'b1;
            op_q     <= op_d;
            faddr_q  <= faddr_d;
            fwdata_q <= fwdata_d;
         end else if (state_q == S_EPW && fl.done) begin
            start_q <= 1'b1;
            op_q    <= FAC_OP_PROG;
         end
      end
   end

   // Core hold; only the core waits, peripherals are untouched
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         core_stall_q <= 1'b0;
         irq_defer_q  <= 1'b0;
      end else begin
         core_stall_q <= state_d != S_IDLE;
         irq_defer_q  <= state_d != S_IDLE;
      end
   end

   // Unlock key
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         key_q <= FAC_RST_UNLOCK;
      end else if (fin || (cmd_wr && !launch)) begin
         key_q <= FAC_RST_UNLOCK;
      end else if (sfr_wr && sfr_addr == FAC_ADR_UNLOCK && state_q == S_IDLE) begin
         key_q <= sfr_wdata;
      end
   end

   // Data register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_q <= FAC_RST_DATA;
      end else if (fin && op_q == FAC_OP_READ) begin
         data_q <= fl.rdata;
      end else if (sfr_wr && sfr_addr == FAC_ADR_DATA && state_q == S_IDLE) begin
         data_q <= sfr_wdata;
      end
   end

   // Plain software registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_q  <= FAC_RST_CMD;
         pkey_q <= FAC_RST_PKEY;
         wpl_q  <= FAC_RST_MASK;
         wpm_q  <= FAC_RST_MASK;
         rp_q   <= FAC_RST_MASK;
         adl_q  <= FAC_RST_ADDR;
         adh_q  <= FAC_RST_ADDR;
      end else if (sfr_wr && state_q == S_IDLE) begin
         unique case (sfr_addr)
            FAC_ADR_CMD:  cmd_q  <= sfr_wdata;
            FAC_ADR_PKEY: pkey_q <= sfr_wdata;
            FAC_ADR_WPL:  wpl_q  <= sfr_wdata;
            FAC_ADR_WPM:  wpm_q  <= sfr_wdata;
            FAC_ADR_RP:   rp_q   <= sfr_wdata;
            FAC_ADR_ADL:  adl_q  <= sfr_wdata;
            FAC_ADR_ADH:  adh_q  <= sfr_wdata;
            default:      cmd_q  <= cmd_q;
         endcase
      end
   end

   // Active protection setup
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_act_q <= '1;
         rp_act_q <= FAC_RST_MASK;
      end else if (apply_masks) begin
         wp_act_q <= {adh_q, adl_q, wpm_q, wpl_q};
         rp_act_q <= rp_q;
      end
   end

   // Mirror of the stored protection key byte
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         stored_key_q <= FAC_ERASED;
      end else if (fin && op_q == FAC_OP_PROG && faddr_q == FAC_PKEY_LOC) begin
         stored_key_q <= stored_key_q & fwdata_q;
      end else if (fl.done && (op_q == FAC_OP_EALL || (op_q == FAC_OP_EPAGE
                  && faddr_q[FAC_ADDR_W-1:FAC_PAGE_W] == FAC_PKEY_LOC[13:9]))) begin
         stored_key_q <= FAC_ERASED;
      end
   end

   // Register read port
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sfr_rdata_q <= 8'h00;
      end else if (sfr_rd) begin
         unique case (sfr_addr)
            FAC_ADR_CMD:    sfr_rdata_q <= cmd_q;
            FAC_ADR_UNLOCK: sfr_rdata_q <= key_q;
            FAC_ADR_PKEY:   sfr_rdata_q <= pkey_q;
            FAC_ADR_DATA:   sfr_rdata_q <= data_q;
            FAC_ADR_WPL:    sfr_rdata_q <= wpl_q;
            FAC_ADR_WPM:    sfr_rdata_q <= wpm_q;
            FAC_ADR_RP:     sfr_rdata_q <= rp_q;
            FAC_ADR_ADL:    sfr_rdata_q <= adl_q;
            FAC_ADR_ADH:    sfr_rdata_q <= adh_q;
            default:        sfr_rdata_q <= 8'h00;
         endcase
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_key_rearm:     assert property (fin |=> key_q == FAC_RST_UNLOCK)
      else $error("unlock key not rearmed");
   a_bad_key_noop:  assert property (cmd_wr && !key_ok |=> !start_q && state_q == S_IDLE)
      else $error("command ran without key");
   a_bad_code_noop: assert property (cmd_wr && !go |=> !start_q ##1 !start_q)
      else $error("unknown code started array");
   a_stall_follows: assert property (core_stall_q == (state_q != S_IDLE))
      else $error("stall does not track operation");
   a_irq_defer:     assert property (irq_defer_q == core_stall_q)
      else $error("interrupt deferral mismatch");
   a_wp_suppress:   assert property (cmd_wr && key_ok && sfr_wdata == FAC_CMD_WRITE
                       && !wp_act_q[page] |=> !start_q)
      else $error("protected page written");
   a_write_launch:  assert property (cmd_wr && key_ok && sfr_wdata == FAC_CMD_WRITE
                       && wp_act_q[page] |=> start_q && op_q == FAC_OP_PROG
                       && faddr_q == $past(addr14))
      else $error("byte write not launched");
   a_read_capture:  assert property (fin && op_q == FAC_OP_READ |=> data_q == $past(fl.rdata))
      else $error("read byte not captured");
   a_epw_program:   assert property (state_q == S_EPW && fl.done |=> start_q
                       && op_q == FAC_OP_PROG)
      else $error("program after erase missing");
   a_key_once:      assert property (cmd_wr && key_ok && sfr_wdata == FAC_CMD_PROT
                       && stored_key_q != FAC_ERASED |=> !start_q)
      else $error("protection key programmed twice");
   a_mask_guard:    assert property (!apply_masks |=> $stable(wp_act_q))
      else $error("protection changed without key");
   a_prog_timing:   assert property (start_q && op_q != FAC_OP_EPAGE && op_q != FAC_OP_EALL
                       |=> fl.done)
      else $error("short operation not done in one cycle");
   a_page_timing:   assert property (start_q && op_q == FAC_OP_EPAGE |-> ##[512:513] fl.done)
      else $error("page erase length wrong");
   // Refused reads and mass erases must not reach the array
   a_read_guard:    assert property (cmd_wr && sfr_wdata == FAC_CMD_READ
                       && !rp_act_q[page[4:2]] |=> !start_q)
      else $error("protected group read");
   a_eall_guard:    assert property (cmd_wr && sfr_wdata == FAC_CMD_EALL
                       && !(&wp_act_q) |=> !start_q)
      else $error("mass erase over protected page");
   a_mask_load:     assert property (apply_masks |=> wp_act_q == {$past(adh_q), $past(adl_q),
                       $past(wpm_q), $past(wpl_q)} && rp_act_q == $past(rp_q))
      else $error("protection masks not loaded");

   c_write:   cover property (fin && op_q == FAC_OP_PROG);
   c_read:    cover property (fin && op_q == FAC_OP_READ);
   c_epw:     cover property (state_q == S_EPW ##[1:600] fin);
   c_protect: cover property (apply_masks);
   c_refused: cover property (cmd_wr && !launch);
endmodule // fac_ctrl

// [hdl/fac_pkg.sv]
package fac_pkg;
   // Register map
   localparam logic [7:0]  FAC_ADR_CMD      = 8'hB9;
   localparam logic [7:0]  FAC_ADR_UNLOCK   = 8'hBA;
   localparam logic [7:0]  FAC_ADR_PKEY     = 8'hBB;
   localparam logic [7:0]  FAC_ADR_DATA     = 8'hBC;
   localparam logic [7:0]  FAC_ADR_WPL      = 8'hBD;
   localparam logic [7:0]  FAC_ADR_WPM      = 8'hBE;
   localparam logic [7:0]  FAC_ADR_RP       = 8'hBF;
   localparam logic [7:0]  FAC_ADR_ADL      = 8'hC6;
   localparam logic [7:0]  FAC_ADR_ADH      = 8'hC7;
   // Reset values
   localparam logic [7:0]  FAC_RST_CMD      = 8'h00;
   localparam logic [7:0]  FAC_RST_UNLOCK   = 8'hFF;
   localparam logic [7:0]  FAC_RST_PKEY     = 8'hFF;
   localparam logic [7:0]  FAC_RST_DATA     = 8'h00;
   localparam logic [7:0]  FAC_RST_MASK     = 8'hFF;
   localparam logic [7:0]  FAC_RST_ADDR     = 8'h00;
   // Key values and array layout
   localparam logic [7:0]  FAC_UNLOCK_VALUE = 8'h3B;
   localparam logic [7:0]  FAC_ERASED       = 8'hFF;
   localparam logic [13:0] FAC_PKEY_LOC     = 14'h3FFA;
   localparam int          FAC_ADDR_W       = 14;
   localparam int          FAC_PAGE_W       = 9;
   localparam int          FAC_PAGES        = 32;
   localparam int          FAC_PAGE_BYTES   = 512;
   // Command codes
   localparam logic [7:0]  FAC_CMD_WRITE    = 8'h01;
   localparam logic [7:0]  FAC_CMD_EPAGE    = 8'h02;
   localparam logic [7:0]  FAC_CMD_EALL     = 8'h03;
   localparam logic [7:0]  FAC_CMD_READ     = 8'h04;
   localparam logic [7:0]  FAC_CMD_EPW      = 8'h05;
   localparam logic [7:0]  FAC_CMD_PROT     = 8'h08;

   typedef enum logic [1:0] {FAC_OP_PROG, FAC_OP_EPAGE, FAC_OP_EALL, FAC_OP_READ} fac_op_t;
endpackage

// [hdl/fac_flash_if.sv]
interface fac_flash_if
   import fac_pkg::*;
   #(parameter int AW = FAC_ADDR_W);
   logic          start;
   fac_op_t       op;
   logic [AW-1:0] addr;
   logic [7:0]    wdata;
   logic [7:0]    rdata;
   logic          done;
   modport ctrl  (output start, op, addr, wdata, input rdata, done);
   modport array (input start, op, addr, wdata, output rdata, done);
endinterface

// [hdl/fac_flash_array.sv]
module fac_flash_array
   import fac_pkg::*;
   #(parameter int AW     = FAC_ADDR_W,
     parameter int PAGE_W = FAC_PAGE_W)
   (input wire logic  core_clk,
    input wire logic  rst_n,
    fac_flash_if.array fl);

   if (AW <= PAGE_W || (1 << AW) != FAC_PAGES * FAC_PAGE_BYTES) begin : g_chk
      $error("fac_flash_array: geometry mismatch");
   end

   logic [7:0]    mem [1 << AW];
   logic          busy_q;
   logic [AW-1:0] ptr_q;
   logic [AW-1:0] end_q;
   logic          done_q;
   logic [7:0]    rdata_q;
   logic          idle_start;

   assign idle_start = fl.start && !busy_q;
   assign fl.done    = done_q;
   assign fl.rdata   = rdata_q;

   // Program clears bits only; erase walks bytes back to erased state
   always_ff @(posedge core_clk) begin
      if (idle_start && fl.op == FAC_OP_PROG) begin
         mem[fl.addr] <= mem[fl.addr] & fl.wdata;
      end else if (busy_q) begin
         mem[ptr_q] <= FAC_ERASED;
      end
   end

   // Erase sequencing
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
         ptr_q  <= '0;
         end_q  <= '0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (idle_start) begin
            unique case (fl.op)
               FAC_OP_EPAGE: begin
                  busy_q <= 1'b1;
                  ptr_q  <= {fl.addr[AW-1:PAGE_W], {PAGE_W{1'b0}}};
                  end_q  <= {fl.addr[AW-1:PAGE_W], {PAGE_W{1'b1}}};
               end
               FAC_OP_EALL: begin
                  busy_q <= 1'b1;
                  ptr_q  <= '0;
                  end_q  <= '1;
               end
               FAC_OP_PROG, FAC_OP_READ: done_q <= 1'b1;
            endcase
         end else if (busy_q) begin
            if (ptr_q == end_q) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end else begin
               ptr_q <= ptr_q + 1'b1;
            end
         end
      end
   end

   // Read port
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else if (idle_start && fl.op == FAC_OP_READ) begin
         rdata_q <= mem[fl.addr];
      end
   end
endmodule // fac_flash_array

// [verification/fac_core_model.sv]
// Core side of the register bus: one access at a time, held off while stalled
module fac_core_model (
   input  wire logic       core_clk,
   input  wire logic       core_stall_q,
   output logic [7:0]      sfr_addr,
   output logic            sfr_wr,
   output logic [7:0]      sfr_wdata,
   output logic            sfr_rd,
   input  wire logic [7:0] sfr_rdata_q
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      sfr_addr  = 8'h00;
      sfr_wr    = 1'b0;
      sfr_wdata = 8'h00;
      sfr_rd    = 1'b0;
   end

   // Core does not fetch the next instruction while the counter is held
   task automatic wait_free();
      @(posedge core_clk);
      #1;
      while (core_stall_q === 1'b1) begin
         @(posedge core_clk);
         #1;
      end
   endtask

   // Key is written by the caller before each command except in the no-key write check
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wait_free();
      sfr_addr  = a;
      sfr_wdata = d;
      sfr_wr    = 1'b1;
      @(posedge core_clk);
      #1;
      sfr_wr    = 1'b0;
      sfr_addr  = ~a;
      sfr_wdata = ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      wait_free();
      sfr_addr = a;
      sfr_rd   = 1'b1;
      @(posedge core_clk);
      #1;
      d        = sfr_rdata_q;
      sfr_rd   = 1'b0;
      sfr_addr = ~a;
   endtask
endmodule // fac_core_model

// [verification/flash_access_controller_test.sv]
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin bad_count++; \
   $display("Error %s expected %h seen %h", nm, exp, got); end end

module flash_access_controller_test
   import fac_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;

   logic       core_clk;
   logic       rst_n;
   logic [7:0] sfr_addr;
   logic       sfr_wr;
   logic [7:0] sfr_wdata;
   logic       sfr_rd;
   logic [7:0] sfr_rdata_q;
   logic       core_stall_q;
   logic       irq_defer_q;
   int         bad_count = 0;
   int         compares  = 0;
   int         n;
   logic [7:0] v;
   logic [7:0] adrs [9] = '{FAC_ADR_CMD, FAC_ADR_UNLOCK, FAC_ADR_PKEY, FAC_ADR_DATA,
                            FAC_ADR_WPL, FAC_ADR_WPM, FAC_ADR_RP, FAC_ADR_ADL, FAC_ADR_ADH};
   logic [7:0] rsts [9] = '{8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00};

   fac_ctrl i_dut (.core_clk(core_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
      .sfr_rdata_q(sfr_rdata_q), .core_stall_q(core_stall_q), .irq_defer_q(irq_defer_q));

   fac_core_model i_core (.core_clk(core_clk), .core_stall_q(core_stall_q),
      .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
      .sfr_rdata_q(sfr_rdata_q));

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic results();
      $display("Comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic set_addr(input logic [13:0] a);
      i_core.wr(FAC_ADR_ADH, {2'b00, a[13:8]});
      i_core.wr(FAC_ADR_ADL, a[7:0]);
   endtask

   // Issue a keyed command and count the cycles the core is held
   task automatic cmd(input logic [7:0] code, output int cnt);
      i_core.wr(FAC_ADR_UNLOCK, FAC_UNLOCK_VALUE);
      i_core.wr(FAC_ADR_CMD, code);
      cnt = 0;
      while (core_stall_q === 1'b1 && cnt < 20000) begin
         cnt++;
         @(posedge core_clk);
         #1;
         `CHK("irq_defer", core_stall_q, irq_defer_q)
      end
   endtask

   task automatic rd_flash(input logic [13:0] a, output logic [7:0] d);
      int c;
      set_addr(a);
      cmd(FAC_CMD_READ, c);
      i_core.rd(FAC_ADR_DATA, d);
   endtask

   task automatic wr_flash(input logic [13:0] a, input logic [7:0] d, input logic [7:0] code,
                           output int cnt);
      i_core.wr(FAC_ADR_DATA, d);
      set_addr(a);
      cmd(code, cnt);
   endtask

   // Protection update with the given keys and masks; address registers act as masks
   task automatic protect(input logic [7:0] k, input logic [7:0] w0, input logic [7:0] w1,
                          input logic [7:0] wl, input logic [7:0] wh, output int cnt);
      i_core.wr(FAC_ADR_PKEY, k);
      i_core.wr(FAC_ADR_WPL, w0);
      i_core.wr(FAC_ADR_WPM, w1);
      i_core.wr(FAC_ADR_ADL, wl);
      i_core.wr(FAC_ADR_ADH, wh);
      cmd(FAC_CMD_PROT, cnt);
   endtask

   initial begin
      repeat (60000) @(posedge core_clk);
      bad_count++;
      results();
   end

   initial begin
      rst_n = 1'b0;
      repeat (12) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      for (int i = 0; i < 9; i++) begin
         i_core.rd(adrs[i], v);
         `CHK("reset value", rsts[i], v)
      end
      i_core.wr(8'hC0, 8'h55);
      i_core.rd(8'hC0, v);
      `CHK("unmapped", 8'h00, v)
      cmd(FAC_CMD_EALL, n);
      `CHK("mass erase stall", 1'b1, n >= 16384)
      rd_flash(14'h3C00, v);
      `CHK("erased byte", FAC_ERASED, v)
      wr_flash(14'h3C00, 8'hF3, FAC_CMD_WRITE, n);
      `CHK("write stall", 2, n)
      i_core.rd(FAC_ADR_UNLOCK, v);
      `CHK("key rearmed", FAC_RST_UNLOCK, v)
      rd_flash(14'h3C00, v);
      `CHK("written byte", 8'hF3, v)
      wr_flash(14'h3C00, 8'h0F, FAC_CMD_WRITE, n);
      rd_flash(14'h3C00, v);
      `CHK("bits only cleared", 8'h03, v)
      i_core.wr(FAC_ADR_DATA, 8'h00);
      i_core.wr(FAC_ADR_CMD, FAC_CMD_WRITE);
      repeat (3) @(posedge core_clk);
      #1;
      `CHK("no key stall", 1'b0, core_stall_q)
      rd_flash(14'h3C00, v);
      `CHK("no key unchanged", 8'h03, v)
      for (int c = 6; c < 8; c++) begin
         cmd(8'(c), n);
         `CHK("unlisted code", 0, n)
         i_core.rd(FAC_ADR_UNLOCK, v);
         `CHK("unlisted rearm", FAC_RST_UNLOCK, v)
      end
      wr_flash(14'h3C05, 8'hA5, FAC_CMD_EPW, n);
      rd_flash(14'h3C05, v);
      `CHK("erase write byte", 8'hA5, v)
      rd_flash(14'h3C00, v);
      `CHK("erase write page", FAC_ERASED, v)
      set_addr(14'h3DFF);
      cmd(FAC_CMD_EPAGE, n);
      `CHK("page erase stall", 1'b1, n >= FAC_PAGE_BYTES)
      rd_flash(14'h3C05, v);
      `CHK("page erased", FAC_ERASED, v)
      protect(8'h5A, 8'hFE, 8'hFF, 8'hFF, 8'hFF, n);
      `CHK("key program", 2, n)
      rd_flash(FAC_PKEY_LOC, v);
      `CHK("stored key", 8'h5A, v)
      wr_flash(14'h0010, 8'h00, FAC_CMD_WRITE, n);
      `CHK("page 0 protected", 0, n)
      rd_flash(14'h0010, v);
      `CHK("page 0 intact", FAC_ERASED, v)
      protect(8'h11, 8'hFF, 8'hFF, 8'hFF, 8'hFF, n);
      `CHK("wrong prot key", 0, n)
      wr_flash(14'h0010, 8'h00, FAC_CMD_WRITE, n);
      `CHK("still protected", 0, n)
      protect(8'h5A, 8'hFF, 8'hFE, 8'hFE, 8'h7F, n);
      `CHK("right prot key", 0, n)
      wr_flash(14'h0010, 8'h00, FAC_CMD_WRITE, n);
      `CHK("page 0 released", 2, n)
      wr_flash(14'h1000, 8'h00, FAC_CMD_WRITE, n);
      `CHK("page 8 protected", 0, n)
      wr_flash(14'h2000, 8'h00, FAC_CMD_EPAGE, n);
      `CHK("page 16 protected", 0, n)
      cmd(FAC_CMD_EALL, n);
      `CHK("mass erase refused", 0, n)
      protect(8'h5A, 8'hFF, 8'hFF, 8'hFF, 8'hFF, n);
      i_core.wr(FAC_ADR_RP, 8'hFE);
      cmd(FAC_CMD_PROT, n);
      i_core.wr(FAC_ADR_DATA, 8'h77);
      rd_flash(14'h0010, v);
      `CHK("read protected", 8'h77, v)
      rd_flash(14'h1000, v);
      `CHK("group 2 readable", FAC_ERASED, v)
      results();
   end
endmodule // flash_access_controller_test
